// ==== common/adc_host_pkg.sv ====
package adc_host_pkg;

  // ==========================================================
  // Core clock and conversion timing
  // ==========================================================
  localparam int unsigned CORE_HZ = 40_000_000;
  localparam int unsigned CYC_PER_US = CORE_HZ / 1_000_000;
  // Lines must be static from this time after start until busy rises.
  localparam int unsigned QUIET_US = 8;
  // Longest time, rounded down.
  localparam int unsigned QUIET_CYC = QUIET_US * CYC_PER_US;
  // Width of the start pulse, a least time rounded up.
  localparam int unsigned PULSE_NS = 1000;
  localparam int unsigned PULSE_CYC = (PULSE_NS * CYC_PER_US + 999) / 1000;
  // Give-up time while waiting for busy to return high.
  localparam int unsigned BUSY_MAX_US = 25;
  localparam int unsigned BUSY_MAX_CYC = BUSY_MAX_US * CYC_PER_US;
  localparam int unsigned CNT_W = $clog2(BUSY_MAX_CYC + 1);
  // A start pulse is issued on every second frame tick.
  localparam int unsigned FRAME_DIV = 2;

  // ==========================================================
  // Word layout and averaging
  // ==========================================================
  localparam int unsigned WORD_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned AVG_MAX_LOG2 = 3;
  localparam int unsigned ACC_W = WORD_W + AVG_MAX_LOG2;

  // ==========================================================
  // Link timing, in link clock cycles
  // ==========================================================
  localparam int unsigned HALF_CYC = 4;
  localparam int unsigned GAP_CYC = 8;
  localparam int unsigned LCNT_W = 4;
  localparam int unsigned BIT_W = 5;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_PULSE = 3'b001,
    ST_WAIT = 3'b010,
    ST_REQ = 3'b011,
    ST_RWAIT = 3'b100,
    ST_FILT = 3'b101,
    ST_PUSH = 3'b110
  } host_state_t;

  typedef enum logic [2:0] {
    LK_IDLE = 3'b000,
    LK_HIGH = 3'b001,
    LK_LOW = 3'b010,
    LK_GAP = 3'b011,
    LK_DONE = 3'b100
  } link_state_t;

  function automatic logic [AVG_MAX_LOG2-1:0] avg_mask(
    input logic [1:0] k
  );
    avg_mask = AVG_MAX_LOG2'((1 << k) - 1);
  endfunction

endpackage

// ==== common/adc_link_if.sv ====
`timescale 1ns/1ps
interface adc_link_if #(
  parameter int CHAN_W = 1
);
  logic req_tgl;
  logic byte_mode;
  logic [CHAN_W-1:0] chan;
  logic done_tgl;
  logic [adc_host_pkg::WORD_W-1:0] word;

  modport core (output req_tgl, output byte_mode, output chan,
                input done_tgl, input word);
  modport link (input req_tgl, input byte_mode, input chan,
                output done_tgl, output word);
endinterface

// ==== hw/adc_conversion_readout_host.sv ====
`timescale 1ns/1ps
// Summary of operation
// - Lines stay static from 8 us until busy rises.
// - Enable serial reads only after busy rising edge.
// - Select only permits access, never frames transfers.
// - Shared start pulse, then read converters in turn.
// - Byte mode saves upper byte before lower arrives.
// - Start pulses come from a hardware timer.
// - Start on every second frame, divider two.
// - Frame rate is twice the conversion rate.
// - Averaging of n results for slow signals.
// - Optional digital filter for faster signals.
module adc_conversion_readout_host #(
  parameter int NUM_ADC = 1,
  parameter int unsigned FRAME_CYC = 500,
  parameter int CHAN_W = (NUM_ADC > 1) ? $clog2(NUM_ADC) : 1
) (
  input wire logic core_clk, // Core clock, 40 MHz.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic link_clk, // Link clock for the serial shifter.
  input wire logic run, // Enable periodic conversions.
  input wire logic byte_mode, // Read as two byte transfers.
  input wire logic filter_en, // Filter instead of block averaging.
  input wire logic [1:0] avg_log2, // Log2 of averaging or filter depth.
  input wire logic clear_flags, // Clear the sticky error flags.
  input wire logic [NUM_ADC-1:0] busy_n, // Converter busy lines, low busy.
  input wire logic sdata, // Shared serial data from converters.
  output logic convert_start_n, // Shared start pulse, active low.
  output logic [NUM_ADC-1:0] cs_n, // Per-converter select, active low.
  output logic data_clk, // Serial data clock out.
  output logic out_valid, // Result word available.
  input wire logic out_ready, // Result word taken.
  output logic [15:0] out_word, // Result word.
  output logic [CHAN_W-1:0] out_chan, // Converter of the result.
  output logic busy_timeout, // Sticky: busy never returned high.
  output logic start_overrun // Sticky: start due while still busy.
);
  localparam int FRAME_W = $clog2(FRAME_CYC + 1);
  localparam int ACC_W = adc_host_pkg::ACC_W;
  localparam int WORD_W = adc_host_pkg::WORD_W;
  localparam int CNT_W = adc_host_pkg::CNT_W;

  // The pulse must be over well before the quiet window opens.
  if (adc_host_pkg::PULSE_CYC >= adc_host_pkg::QUIET_CYC) begin : g_chk_p
    $error("start pulse overlaps the quiet window");
  end
  if (NUM_ADC < 1 || FRAME_CYC < 2) begin : g_chk_n
    $error("unsupported converter count or frame length");
  end

  adc_link_if #(.CHAN_W(CHAN_W)) lnk ();

  adc_link_shift #(.NUM_ADC(NUM_ADC), .CHAN_W(CHAN_W)) u_link (
    .link_clk(link_clk),
    .nrst(nrst),
    .lnk(lnk.link),
    .cs_n(cs_n),
    .data_clk(data_clk),
    .sdata(sdata)
  );

  logic buf_in_ready;
  logic buf_in_valid;
  logic [WORD_W+CHAN_W-1:0] buf_in_data;

  adc_result_buf #(.W(WORD_W + CHAN_W)) u_buf (
    .clk(core_clk),
    .nrst(nrst),
    .in_valid(buf_in_valid),
    .in_ready(buf_in_ready),
    .in_data(buf_in_data),
    .out_valid(out_valid),
    .out_ready(out_ready),
    .out_data({out_chan, out_word})
  );

  // ==========================================================
  // Synchronisers
  // ==========================================================
  logic [NUM_ADC-1:0] busy_s1, busy_s2, busy_d;
  logic done_s1, done_s2;

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      busy_s1 <= '1;
      busy_s2 <= '1;
      busy_d <= '1;
      done_s1 <= 1'b0;
      done_s2 <= 1'b0;
    end else begin
      busy_s1 <= busy_n;
      busy_s2 <= busy_s1;
      busy_d <= busy_s2;
      done_s1 <= lnk.done_tgl;
      done_s2 <= done_s1;
    end
  end

  // ==========================================================
  // Frame timer
  // ==========================================================
  // A hardware frame timer runs at twice the conversion rate and only
  // every second frame starts a conversion, so start jitter is nil.
  logic [FRAME_W-1:0] frame_cnt, next_frame_cnt;
  logic frame_odd, next_frame_odd;
  logic start_tick, next_start_tick;
  logic frame_wrap;

  always_comb begin
    frame_wrap = (frame_cnt == FRAME_W'(FRAME_CYC - 1));
    next_frame_cnt = frame_wrap ? '0 : frame_cnt + 1'b1;
    next_frame_odd = frame_wrap ? ~frame_odd : frame_odd;
    next_start_tick = frame_wrap & frame_odd & run;
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      frame_cnt <= '0;
      frame_odd <= 1'b0;
      start_tick <= 1'b0;
    end else begin
      frame_cnt <= next_frame_cnt;
      frame_odd <= next_frame_odd;
      start_tick <= next_start_tick;
    end
  end

  // ==========================================================
  // Sequencer
  // ==========================================================
  adc_host_pkg::host_state_t state, next_state;
  logic [CNT_W-1:0] cnt, next_cnt;
  logic [CHAN_W-1:0] chan, next_chan;
  logic convert_start_n_n, next_convert_start_n_n;
  logic req_tgl, next_req_tgl;
  logic lnk_byte, next_lnk_byte;
  logic [CHAN_W-1:0] lnk_chan, next_lnk_chan;
  logic done_seen, next_done_seen;
  logic [NUM_ADC-1:0] done_mask, next_done_mask;
  logic [WORD_W-1:0] sample, next_sample, result, next_result;
  logic [ACC_W-1:0] acc [NUM_ADC];
  logic [ACC_W-1:0] next_acc [NUM_ADC];
  logic [adc_host_pkg::AVG_MAX_LOG2-1:0] avg_cnt, next_avg_cnt;
  logic emit, next_emit;
  logic next_timeout, next_overrun;
  logic [ACC_W-1:0] a;
  logic [adc_host_pkg::AVG_MAX_LOG2-1:0] mask;

  assign convert_start_n = convert_start_n_n;
  assign lnk.req_tgl = req_tgl;
  assign lnk.byte_mode = lnk_byte;
  assign lnk.chan = lnk_chan;
  assign buf_in_valid = (state == adc_host_pkg::ST_PUSH) & emit;
  assign buf_in_data = {chan, result};

  always_comb begin
    a = '0;
    mask = adc_host_pkg::avg_mask(avg_log2);
    next_state = state;
    next_cnt = cnt;
    next_chan = chan;
    next_convert_start_n_n = convert_start_n_n;
    next_req_tgl = req_tgl;
    next_lnk_byte = lnk_byte;
    next_lnk_chan = lnk_chan;
    next_done_seen = done_seen;
    next_done_mask = done_mask;
    next_sample = sample;
    next_result = result;
    next_acc = acc;
    next_avg_cnt = avg_cnt;
    next_emit = emit;
    // Set wins over a simultaneous clear.
    next_overrun = (start_tick && state != adc_host_pkg::ST_IDLE) |
                   (start_overrun & ~clear_flags);
    next_timeout = busy_timeout & ~clear_flags;
    unique case (state)
      adc_host_pkg::ST_IDLE: begin
        if (start_tick) begin
          // One pulse starts every converter together.
          next_convert_start_n_n = 1'b0;
          next_cnt = '0;
          next_done_mask = '0;
          next_state = adc_host_pkg::ST_PULSE;
        end
      end
      adc_host_pkg::ST_PULSE: begin
        next_cnt = cnt + 1'b1;
        if (cnt == CNT_W'(adc_host_pkg::PULSE_CYC - 1)) begin
          next_convert_start_n_n = 1'b1;
          next_cnt = '0;
          next_state = adc_host_pkg::ST_WAIT;
        end
      end
      adc_host_pkg::ST_WAIT: begin
        // Nothing moves here, which also covers the late bit decisions
        // that can no longer be corrected.
        next_done_mask = done_mask | (busy_s2 & ~busy_d);
        if (&next_done_mask) begin
          // Serial access opens only after every busy line has risen.
          next_chan = '0;
          next_state = adc_host_pkg::ST_REQ;
        end else if (cnt == CNT_W'(adc_host_pkg::BUSY_MAX_CYC - 1)) begin
          next_timeout = 1'b1;
          next_state = adc_host_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt + 1'b1;
        end
      end
      adc_host_pkg::ST_REQ: begin
        next_req_tgl = ~req_tgl;
        next_lnk_byte = byte_mode;
        next_lnk_chan = chan;
        next_state = adc_host_pkg::ST_RWAIT;
      end
      adc_host_pkg::ST_RWAIT: begin
        // The word is held by the link until the next request.
        if (done_s2 != done_seen) begin
          next_done_seen = done_s2;
          next_sample = lnk.word;
          next_state = adc_host_pkg::ST_FILT;
        end
      end
      adc_host_pkg::ST_FILT: begin
        a = acc[chan];
        if (filter_en) begin
          // First-order low-pass: each step down in bandwidth buys SNR.
          a = a + ACC_W'(sample) - (a >> avg_log2);
          next_emit = 1'b1;
        end else begin
          a = a + ACC_W'(sample);
          next_emit = (avg_cnt == mask);
        end
        next_result = WORD_W'(a >> avg_log2);
        next_acc[chan] = (!filter_en && avg_cnt == mask) ? '0 : a;
        next_state = adc_host_pkg::ST_PUSH;
      end
      adc_host_pkg::ST_PUSH: begin
        if (!emit || buf_in_ready) begin
          if (chan == CHAN_W'(NUM_ADC - 1)) begin
            // Block averaging counts whole frames of all converters.
            if (filter_en || avg_cnt == mask) begin
              next_avg_cnt = '0;
            end else begin
              next_avg_cnt = avg_cnt + 1'b1;
            end
            next_state = adc_host_pkg::ST_IDLE;
          end else begin
            // Converters are read one after another.
            next_chan = chan + 1'b1;
            next_state = adc_host_pkg::ST_REQ;
          end
        end
      end
      default: begin
        next_state = adc_host_pkg::ST_IDLE;
        next_convert_start_n_n = 1'b1;
      end
    endcase
  end

  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      state <= adc_host_pkg::ST_IDLE;
      cnt <= '0;
      chan <= '0;
      convert_start_n_n <= 1'b1;
      req_tgl <= 1'b0;
      lnk_byte <= 1'b0;
      lnk_chan <= '0;
      done_seen <= 1'b0;
      done_mask <= '0;
      sample <= '0;
      result <= '0;
      for (int i = 0; i < NUM_ADC; i++) begin
        acc[i] <= '0;
      end
      avg_cnt <= '0;
      emit <= 1'b0;
      busy_timeout <= 1'b0;
      start_overrun <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      chan <= next_chan;
      convert_start_n_n <= next_convert_start_n_n;
      req_tgl <= next_req_tgl;
      lnk_byte <= next_lnk_byte;
      lnk_chan <= next_lnk_chan;
      done_seen <= next_done_seen;
      done_mask <= next_done_mask;
      sample <= next_sample;
      result <= next_result;
      acc <= next_acc;
      avg_cnt <= next_avg_cnt;
      emit <= next_emit;
      busy_timeout <= next_timeout;
      start_overrun <= next_overrun;
    end
  end
endmodule

// ==== hw/adc_link_shift.sv ====
`timescale 1ns/1ps
module adc_link_shift #(
  parameter int NUM_ADC = 1,
  parameter int CHAN_W = 1
) (
  input wire logic link_clk, // Link clock.
  input wire logic nrst, // Asynchronous reset, active low.
  adc_link_if.link lnk, // Request and result toward the core.
  output logic [NUM_ADC-1:0] cs_n, // Per-converter select, active low.
  output logic data_clk, // Serial data clock out.
  input wire logic sdata // Serial data in.
);
  logic req_s1, req_s2, req_seen;
  logic din_s1, din_s2;
  adc_host_pkg::link_state_t state, next_state;
  logic [adc_host_pkg::LCNT_W-1:0] cnt, next_cnt;
  logic [adc_host_pkg::BIT_W-1:0] bits, next_bits;
  logic [adc_host_pkg::WORD_W-1:0] shift, next_shift, word, next_word;
  logic [adc_host_pkg::BYTE_W-1:0] msb_byte, next_msb_byte;
  logic next_req_seen, done_tgl, next_done_tgl, next_dclk;
  logic [NUM_ADC-1:0] next_cs_n;
  localparam int LCNT_W = adc_host_pkg::LCNT_W;
  localparam int BIT_W = adc_host_pkg::BIT_W;

  assign lnk.done_tgl = done_tgl;
  assign lnk.word = word;

  // ==========================================================
  // Synchronisers
  // ==========================================================
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      req_s1 <= 1'b0;
      req_s2 <= 1'b0;
      din_s1 <= 1'b0;
      din_s2 <= 1'b0;
    end else begin
      req_s1 <= lnk.req_tgl;
      req_s2 <= req_s1;
      din_s1 <= sdata;
      din_s2 <= din_s1;
    end
  end

  // ==========================================================
  // Shifter
  // ==========================================================
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_bits = bits;
    next_shift = shift;
    next_word = word;
    next_msb_byte = msb_byte;
    next_req_seen = req_seen;
    next_done_tgl = done_tgl;
    next_dclk = data_clk;
    next_cs_n = cs_n;
    unique case (state)
      adc_host_pkg::LK_IDLE: begin
        if (req_s2 != req_seen) begin
          next_req_seen = req_s2;
          // Select only grants access; framing comes from the bit count.
          next_cs_n = ~(NUM_ADC'(1) << lnk.chan);
          next_bits = '0;
          next_cnt = '0;
          next_dclk = 1'b1;
          next_state = adc_host_pkg::LK_HIGH;
        end
      end
      adc_host_pkg::LK_HIGH: begin
        next_cnt = cnt + 1'b1;
        if (cnt == LCNT_W'(adc_host_pkg::HALF_CYC - 1)) begin
          next_cnt = '0;
          next_dclk = 1'b0;
          next_state = adc_host_pkg::LK_LOW;
        end
      end
      adc_host_pkg::LK_LOW: begin
        next_cnt = cnt + 1'b1;
        if (cnt == LCNT_W'(adc_host_pkg::HALF_CYC - 1)) begin
          next_cnt = '0;
          // Most significant bit arrives first.
          next_shift = {shift[adc_host_pkg::WORD_W-2:0], din_s2};
          next_bits = bits + 1'b1;
          // Sixteen decisions make one result.
          if (bits == BIT_W'(adc_host_pkg::WORD_W - 1)) begin
            next_state = adc_host_pkg::LK_DONE;
          end else if (lnk.byte_mode &&
                       bits == BIT_W'(adc_host_pkg::BYTE_W - 1)) begin
            // Keep the upper byte before the lower one overwrites it.
            next_msb_byte = next_shift[adc_host_pkg::BYTE_W-1:0];
            next_state = adc_host_pkg::LK_GAP;
          end else begin
            next_dclk = 1'b1;
            next_state = adc_host_pkg::LK_HIGH;
          end
        end
      end
      adc_host_pkg::LK_GAP: begin
        next_cnt = cnt + 1'b1;
        if (cnt == LCNT_W'(adc_host_pkg::GAP_CYC - 1)) begin
          next_cnt = '0;
          next_dclk = 1'b1;
          next_state = adc_host_pkg::LK_HIGH;
        end
      end
      adc_host_pkg::LK_DONE: begin
        if (lnk.byte_mode) begin
          next_word = {msb_byte, shift[adc_host_pkg::BYTE_W-1:0]};
        end else begin
          next_word = shift;
        end
        next_done_tgl = ~done_tgl;
        next_cs_n = '1;
        next_state = adc_host_pkg::LK_IDLE;
      end
      default: begin
        next_state = adc_host_pkg::LK_IDLE;
        next_cs_n = '1;
        next_dclk = 1'b0;
      end
    endcase
  end

  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) begin
      state <= adc_host_pkg::LK_IDLE;
      cnt <= '0;
      bits <= '0;
      shift <= '0;
      word <= '0;
      msb_byte <= '0;
      req_seen <= 1'b0;
      done_tgl <= 1'b0;
      data_clk <= 1'b0;
      cs_n <= '1;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      bits <= next_bits;
      shift <= next_shift;
      word <= next_word;
      msb_byte <= next_msb_byte;
      req_seen <= next_req_seen;
      done_tgl <= next_done_tgl;
      data_clk <= next_dclk;
      cs_n <= next_cs_n;
    end
  end
endmodule

// ==== hw/adc_result_buf.sv ====
`timescale 1ns/1ps
module adc_result_buf #(
  parameter int W = 17
) (
  input wire logic clk, // Core clock.
  input wire logic nrst, // Asynchronous reset, active low.
  input wire logic in_valid, // Word offered.
  output logic in_ready, // Room for a word.
  input wire logic [W-1:0] in_data, // Word in.
  output logic out_valid, // Head word present.
  input wire logic out_ready, // Head word taken.
  output logic [W-1:0] out_data // Head word.
);
  logic v0, v1;
  logic [W-1:0] d0, d1;
  logic next_v0, next_v1;
  logic [W-1:0] next_d0, next_d1;
  logic pop, push;

  // Slot 0 is always the head so the outputs come straight from flops.
  assign in_ready = ~v1;
  assign out_valid = v0;
  assign out_data = d0;
  assign pop = v0 & out_ready;
  assign push = in_valid & ~v1;

  always_comb begin
    next_v0 = v0;
    next_v1 = v1;
    next_d0 = d0;
    next_d1 = d1;
    if (pop) begin
      if (v1) begin
        next_d0 = d1;
        next_v1 = 1'b0;
      end else begin
        next_v0 = 1'b0;
      end
    end
    if (push) begin
      if (!next_v0) begin
        next_d0 = in_data;
        next_v0 = 1'b1;
      end else begin
        next_d1 = in_data;
        next_v1 = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      v0 <= 1'b0;
      v1 <= 1'b0;
      d0 <= '0;
      d1 <= '0;
    end else begin
      v0 <= next_v0;
      v1 <= next_v1;
      d0 <= next_d0;
      d1 <= next_d1;
    end
  end
endmodule

// ==== verif/adc_conversion_readout_host_tb_top.sv ====
`timescale 1ns/1ps
module adc_conversion_readout_host_tb_top;
  logic core_clk, link_clk, nrst, run, byte_mode, filter_en, clear_flags;
  logic out_ready, sdata, convert_start_n, data_clk, out_valid, stall, hang;
  logic busy_timeout, start_overrun;
  logic [1:0] avg_log2, busy_n, cs_n, sd;
  logic [15:0] out_word;
  logic [0:0] out_chan;
  logic [15:0] val [2];
  logic [16:0] expq [$];
  logic [16:0] e;
  int n_mismatch, checks_done, nfr;
  int acc [2];

  adc_conversion_readout_host #(.NUM_ADC(2), .FRAME_CYC(1500)) i_dut (.*);
  adc_convert_start_n_model #(.CONVERT_START_N_NS(9000)) i_m0 (.start_n(convert_start_n),
    .sel_n(cs_n[0]), .dclk(data_clk), .hang(hang), .value(val[0]),
    .busy_n(busy_n[0]), .sd(sd[0]));
  adc_convert_start_n_model #(.CONVERT_START_N_NS(14000)) i_m1 (.start_n(convert_start_n),
    .sel_n(cs_n[1]), .dclk(data_clk), .hang(hang), .value(val[1]),
    .busy_n(busy_n[1]), .sd(sd[1]));
  assign sdata = cs_n[0] ? sd[1] : sd[0];

  initial begin
    core_clk = 1'b0;
    forever #12.5 core_clk = ~core_clk;
  end
  initial begin
    link_clk = 1'b0;
    #7;
    forever #80 link_clk = ~link_clk;
  end

  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checks_done++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("mismatches=%0d checks=%0d", n_mismatch, checks_done);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Bounded wait; a bound used up counts once and ends the run.
  task automatic wait_on(input int sel, input int lim);
    int i;
    i = 0;
    while (i < lim && (sel == 0 ? convert_start_n !== 1'b0 :
           sel == 1 ? busy_timeout !== 1'b1 :
           sel == 2 ? start_overrun !== 1'b1 : expq.size() != 0)) begin
      @(negedge core_clk);
      i++;
    end
    if (i == lim) begin
      check(17'h0, 17'h1);
      wrap_up();
    end
  endtask

  function automatic void predict(input int c, input int v);
    int k;
    k = avg_log2;
    if (filter_en) begin
      acc[c] = acc[c] + v - (acc[c] >> k);
      expq.push_back({c[0], 16'(acc[c] >> k)});
    end else begin
      acc[c] = acc[c] + v;
      if ((nfr + 1) % (1 << k) == 0) begin
        expq.push_back({c[0], 16'(acc[c] >> k)});
        acc[c] = 0;
      end
    end
  endfunction

  task automatic frame(input logic bm, input logic stl, input logic hg);
    wait_on(0, 4000);
    byte_mode = bm;
    stall = stl;
    hang = hg;
    if (!hg) begin
      predict(0, val[0]);
      predict(1, val[1]);
      nfr++;
    end
    val[0] = 16'($urandom);
    val[1] = 16'($urandom);
    // Let the pulse end so the next frame waits for a new start.
    repeat (adc_host_pkg::PULSE_CYC) @(negedge core_clk);
  endtask

  task automatic do_reset(input int m);
    nrst = 1'b0;
    run = 1'b0;
    filter_en = (m == 2);
    avg_log2 = (m == 1) ? 2'd2 : {1'b0, m == 2};
    acc = '{0, 0};
    nfr = 0;
    val[0] = m[0] ? 16'h8000 : 16'hffff;
    val[1] = (m == 1) ? 16'hffff : 16'h0000;
    // Ten core cycles span a link edge, so both domains see it.
    repeat (10) @(negedge core_clk);
    nrst = 1'b1;
    @(negedge core_clk);
    run = 1'b1;
  endtask

  always @(negedge core_clk) out_ready <= !stall && $urandom_range(3) != 0;

  always @(posedge core_clk) if (nrst && out_valid === 1'b1 && out_ready) begin
    e = expq.size() ? expq.pop_front() : 17'h1ffff;
    check({out_chan, out_word}, e);
  end

  initial begin
    {nrst, run, byte_mode, filter_en, clear_flags, stall, hang} = '0;
    avg_log2 = 2'd0;
    val = '{16'h0, 16'h0};
    void'($urandom(32'h19ee));
    for (int m = 0; m < 3; m++) begin
      do_reset(m);
      for (int f = 0; f < 4; f++) begin
        frame(1'($urandom_range(1)), 1'b0, m == 2 && f == 1);
        if (hang) begin
          wait_on(1, 2000);
          check({16'h0, busy_timeout}, 17'h1);
          hang = 1'b0;
          clear_flags = 1'b1;
          @(negedge core_clk);
          clear_flags = 1'b0;
          @(negedge core_clk);
          check({16'h0, busy_timeout}, 17'h0);
        end
      end
      if (m == 2) begin
        frame(1'b1, 1'b1, 1'b0);
        frame(1'b0, 1'b1, 1'b0);
        wait_on(2, 8000);
        check({16'h0, start_overrun}, 17'h1);
        clear_flags = 1'b1;
      end
      run = 1'b0;
      stall = 1'b0;
      @(negedge core_clk);
      clear_flags = 1'b0;
      wait_on(3, 12000);
    end
    wrap_up();
  end
endmodule

// ==== verif/adc_convert_start_n_model.sv ====
`timescale 1ns/1ps
module adc_convert_start_n_model #(
  parameter int CONVERT_START_N_NS = 12000
) (
  input wire logic start_n, // Shared start pulse.
  input wire logic sel_n, // Select, low.
  input wire logic dclk, // Data clock.
  input wire logic hang, // Hold busy low.
  input wire logic [15:0] value, // Next sample.
  output logic busy_n, // Busy, low.
  output logic sd // Serial data.
);
  logic [15:0] word;
  int idx;
  initial begin
    busy_n = 1'b1;
    sd = 1'b0;
    idx = 0;
  end
  always @(negedge start_n) begin
    busy_n = 1'b0;
    word = value;
    #(CONVERT_START_N_NS);
    wait (!hang);
    busy_n = 1'b1;
  end
  // A released line keeps changing, so a stale bit is never read back.
  always #35 if (sel_n) sd = ~sd;
  always @(posedge sel_n) idx = 0;
  always @(negedge dclk) if (!sel_n) begin
    sd <= word[15 - idx];
    idx = idx + 1;
  end
endmodule

// ==== verif/adc_host_monitor.sv ====
`timescale 1ns/1ps
module adc_host_monitor #(
  parameter int NUM_ADC = 1,
  parameter int unsigned FRAME_CYC = 500,
  parameter int CHAN_W = 1
) (
  input wire logic core_clk, // Core clock.
  input wire logic nrst, // Reset, low.
  input wire logic link_clk, // Link clock.
  input wire logic clear_flags, // Flag clear.
  input wire logic [NUM_ADC-1:0] busy_n, // Busy lines.
  input wire logic convert_start_n, // Start pulse.
  input wire logic [NUM_ADC-1:0] cs_n, // Selects.
  input wire logic data_clk, // Data clock.
  input wire logic out_valid, // Word present.
  input wire logic out_ready, // Word taken.
  input wire logic [15:0] out_word, // Word.
  input wire logic [CHAN_W-1:0] out_chan, // Channel.
  input wire logic busy_timeout, // Timeout flag.
  input wire logic start_overrun // Overrun flag.
);
  logic [15:0] lo_cnt;
  logic [31:0] gap;
  logic armed;
  logic rd_ok;
  logic [4:0] edges;
  always_ff @(posedge core_clk or negedge nrst) begin
    if (!nrst) begin
      lo_cnt <= '0;
      gap <= '0;
      armed <= 1'b0;
      rd_ok <= 1'b0;
    end else begin
      lo_cnt <= convert_start_n ? '0 : lo_cnt + 16'd1;
      gap <= convert_start_n ? gap + 32'd1 : '0;
      armed <= armed | !convert_start_n;
      rd_ok <= !convert_start_n ? 1'b0 : rd_ok | (&busy_n);
    end
  end
  always_ff @(posedge link_clk or negedge nrst) begin
    if (!nrst) edges <= '0;
    else if (&cs_n) edges <= '0;
    else if ($rose(data_clk)) edges <= edges + 5'd1;
  end
  // ==========================================================
  // Core domain
  // ==========================================================
  a_pulse_width: assert property (@(posedge core_clk)
    disable iff (!nrst)
    $rose(convert_start_n) |-> lo_cnt == adc_host_pkg::PULSE_CYC)
    else $error("start pulse width wrong");
  a_start_spacing: assert property (@(posedge core_clk)
    disable iff (!nrst) $fell(convert_start_n) && armed |->
    (gap + adc_host_pkg::PULSE_CYC) % (2 * FRAME_CYC) == 0)
    else $error("start spacing off frame grid");
  a_read_after_busy: assert property (@(posedge core_clk)
    disable iff (!nrst) cs_n != '1 |-> rd_ok)
    else $error("read before busy rose");
  a_quiet_link: assert property (@(posedge core_clk)
    disable iff (!nrst) !(&busy_n) |-> &cs_n && !data_clk)
    else $error("link moved while busy");
  a_quiet_start: assert property (@(posedge core_clk)
    disable iff (!nrst)
    convert_start_n && !(&busy_n) |=> convert_start_n)
    else $error("start moved while busy");
  a_hold_stall: assert property (@(posedge core_clk) disable iff (!nrst)
    out_valid && !out_ready |=> out_valid && $stable({out_chan, out_word}))
    else $error("word changed under stall");
  a_flag_clear: assert property (@(posedge core_clk) disable iff (!nrst)
    $fell(start_overrun) || $fell(busy_timeout) |-> $past(clear_flags))
    else $error("flag dropped without clear");
  // ==========================================================
  // Link domain, then the core-clock covers
  // ==========================================================
  a_bit_count: assert property (@(posedge link_clk)
    disable iff (!nrst) $rose(&cs_n) |-> edges == 5'd16)
    else $error("read not 16 clocks");
  a_one_select: assert property (@(posedge link_clk)
    disable iff (!nrst) $onehot0(~cs_n))
    else $error("two converters selected");
  a_clock_frames: assert property (@(posedge link_clk)
    disable iff (!nrst) $fell(&cs_n) |-> data_clk)
    else $error("first clock not with select");
  c_timeout: cover property (@(posedge core_clk) $rose(busy_timeout));
  c_overrun: cover property (@(posedge core_clk) $rose(start_overrun));
  c_stall: cover property (@(posedge core_clk) out_valid && !out_ready);
endmodule

bind adc_conversion_readout_host adc_host_monitor #(.NUM_ADC(NUM_ADC),
  .FRAME_CYC(FRAME_CYC), .CHAN_W(CHAN_W)) i_mon (.*);
